// ==== core/sbm_pin_sync.sv ====
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to core_clk_i
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sbm_pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic [WIDTH-1:0] pin_i, // Raw pins
  output logic [WIDTH-1:0] sync_o // Filtered level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ==========================================================================
  // Stage one is read only by stage two
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per-bit agreement, so a bit in transit does not glitch its neighbours
  for (genvar g = 0; g < WIDTH; g++) begin : g_agree
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        sync_o[g] <= INIT[g];
      end else if (stage2[g] == stage3[g]) begin
        sync_o[g] <= stage3[g];
      end
    end
  end
endmodule // sbm_pin_sync
`default_nettype wire

// ==== core/sbm_pkg.sv ====
// Purpose: Shared constants and carriers for the mode and status register bank
// Assumes: 16-bit host register bus, word addressed by A5..A1
// Notes: Offsets are byte addresses; the word index is the offset shifted right by one
package sbm_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned ADR_W = 5;
  localparam logic [ADR_W-1:0] MODE_IDX = 5'h00; // Byte offset 0x00
  localparam logic [ADR_W-1:0] STATUS_IDX = 5'h01; // Byte offset 0x02
  localparam logic [15:0] MODE_RESET = 16'h0002; // Only the insert bit starts set
  localparam logic [15:0] MODE_WMASK = 16'h6ecf; // Unused bits 15,12,8,5,4 stay zero
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // ==========================================================================
  // Bank organisation codes
  localparam logic [1:0] BANK_ONE = 2'h0;
  localparam logic [1:0] BANK_TWO = 2'h1;
  localparam int unsigned NUM_BANKS = 4;
  localparam logic [NUM_BANKS-1:0] BANKS_ONE_MASK = 4'h1;
  localparam logic [NUM_BANKS-1:0] BANKS_TWO_MASK = 4'h3;
  localparam logic [NUM_BANKS-1:0] BANKS_FOUR_MASK = 4'hf;
  localparam logic [7:0] PAD_ZERO = 8'h00;
  localparam logic [7:0] PAD_ONES = 8'hff;
  localparam logic [7:0] BUSY_MODE_CODE = 8'h03; // Enter-busy-mode instruction

  // ==========================================================================
  // Operating mode control word, bit 15 first
  typedef struct packed {
    logic unused15;
    logic [1:0] bank_div;
    logic unused12;
    logic chain_write;
    logic chain_en;
    logic block_in;
    logic unused8;
    logic pad_ones;
    logic stay_awake;
    logic unused5;
    logic unused4;
    logic status_select;
    logic cycle_master_enable;
    logic tcode_insert;
    logic self_identification_store;
  } sbm_mode_s;

  // Live state reported by the rest of the controller (same clock)
  typedef struct packed {
    logic instruction_busy;
    logic bus_reset;
    logic bus_reset_done; // Pulse at end of bus reset
    logic won_root;
    logic forced_sleep;
    logic xfer_active;
    logic iso_cycle;
    logic atx_empty;
    logic arx_empty;
    logic atx_full;
    logic arx_full;
    logic [NUM_BANKS-1:0] bank_has_data;
    logic [NUM_BANKS-1:0] bank_full;
    logic int_pending;
    logic rx_async_pkt; // Pulse per received async packet
    logic rx_selfid_pkt; // Pulse per stored or seen self-ID packet
    logic rx_chain_read_resp; // Current packet is a chained block read response
    logic instr_strobe; // Pulse when an instruction is written
    logic [7:0] instr_code;
    logic busy_clear; // Pulse that leaves busy mode
  } sbm_core_s;

endpackage

// ==== core/sbm_regs.sv ====
// Purpose: Operating mode control and status flag registers of the serial bus controller
// Assumes: Host strobes are asynchronous pins; core state arrives on core_clk_i
// Notes: Reads are free of side effects; status is sampled live while read strobe is low
`timescale 1ns/1ps
`default_nettype none
module sbm_regs (
  input wire logic core_clk_i, // 200 MHz core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic cs_b_i, // Chip select pin, active low
  input wire logic rd_b_i, // Read strobe pin, active low
  input wire logic wr_b_i, // Write strobe pin, active low
  input wire logic [sbm_pkg::ADR_W-1:0] adr_i, // Word address A5..A1
  input wire logic [15:0] dat_i, // Data bus input
  output logic [15:0] dat_o, // Data bus output
  output logic dat_oe_o, // Data bus drive enable
  input wire logic pll_locked_i, // PLL lock, asynchronous
  input wire sbm_pkg::sbm_core_s core_i, // Live core state
  output sbm_pkg::sbm_mode_s mode_o, // Mode register contents
  output logic [sbm_pkg::NUM_BANKS-1:0] banks_used_o, // Active bank mask
  output logic [7:0] pad_fill_o, // Fill byte for short payloads
  output logic block_to_shared_o, // Route block writes to shared FIFO
  output logic layers_run_o, // Protocol layers out of internal reset
  output logic sleep_allowed_o, // Sleep instruction may sleep the port
  output logic link_state_valid_o, // Connection indications valid
  output logic cycle_master_o, // Acting as cycle master
  output logic selfid_keep_o, // Store self-ID packets
  output logic rx_busy_o, // Busy mode flag
  output logic ack_busy_o // Answer current async packet with busy
);
  // ==========================================================================
  // Pin synchronisation
  localparam int unsigned PIN_W = 3 + sbm_pkg::ADR_W + 16 + 1;
  localparam logic [PIN_W-1:0] PIN_INIT = {3'h7, {(PIN_W-3){1'b0}}};
  logic [PIN_W-1:0] pins_s;
  logic cs_b_s;
  logic rd_b_s;
  logic wr_b_s;
  logic [sbm_pkg::ADR_W-1:0] adr_s;
  logic [15:0] dat_s;
  logic pll_s;

  sbm_pin_sync #(.WIDTH(PIN_W), .INIT(PIN_INIT)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i({cs_b_i, rd_b_i, wr_b_i, adr_i, dat_i, pll_locked_i}),
    .sync_o(pins_s)
  );
  assign {cs_b_s, rd_b_s, wr_b_s, adr_s, dat_s, pll_s} = pins_s;

  // ==========================================================================
  // Bank decode, used by routing and by three status flags
  function automatic logic [sbm_pkg::NUM_BANKS-1:0] bank_mask(input logic [1:0] div);
    if (div == sbm_pkg::BANK_ONE) begin
      bank_mask = sbm_pkg::BANKS_ONE_MASK;
    end else if (div == sbm_pkg::BANK_TWO) begin
      bank_mask = sbm_pkg::BANKS_TWO_MASK;
    end else begin
      bank_mask = sbm_pkg::BANKS_FOUR_MASK; // Lower bit ignored
    end
  endfunction

  // ==========================================================================
  // Write strobe: commit on the rising edge of the filtered strobe
  logic wr_b_d;
  logic wr_cs;
  logic wr_commit;
  sbm_pkg::sbm_mode_s mode;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_b_d <= 1'b1;
      wr_cs <= 1'b0;
    end else begin
      wr_b_d <= wr_b_s;
      if (!wr_b_s) begin
        wr_cs <= !cs_b_s; // Select seen while strobe low
      end
    end
  end
  // Address and data are still stable at the strobe's release
  assign wr_commit = wr_cs && wr_b_s && !wr_b_d;

  // Mode register; status and unmapped words ignore writes
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode <= sbm_pkg::MODE_RESET;
    end else if (wr_commit && adr_s == sbm_pkg::MODE_IDX) begin
      mode <= dat_s & sbm_pkg::MODE_WMASK;
    end
  end
  // Chain enable is cleared only by a software write or by reset, never by a suspend event
  assign mode_o = mode;

  // ==========================================================================
  // Mode-driven outputs
  assign banks_used_o = bank_mask(mode.bank_div);
  assign pad_fill_o = mode.pad_ones ? sbm_pkg::PAD_ONES : sbm_pkg::PAD_ZERO;
  // Software keeps block_in low while chaining, so chain data is never diverted
  assign block_to_shared_o = mode.block_in;
  assign sleep_allowed_o = !mode.stay_awake;
  assign link_state_valid_o = mode.stay_awake || !core_i.forced_sleep;
  assign selfid_keep_o = mode.self_identification_store;
  // Chain direction and tcode insert act through mode_o.chain_write and
  // mode_o.tcode_insert in the packet engines

  // ==========================================================================
  // Internal reset release; lock loss after release is not re-armed
  logic released;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      released <= 1'b0;
    end else if (pll_s) begin
      released <= 1'b1;
    end
  end
  assign layers_run_o = released;

  // ==========================================================================
  // Cycle master: decided once per bus reset
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cycle_master_o <= 1'b0;
    end else if (core_i.bus_reset_done) begin
      cycle_master_o <= mode.cycle_master_enable && core_i.won_root;
    end else if (core_i.bus_reset) begin
      cycle_master_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Busy mode: a set in the same cycle as a clear wins
  logic busy_set;
  assign busy_set = released && (core_i.rx_async_pkt || core_i.rx_selfid_pkt ||
    (core_i.instr_strobe && core_i.instr_code == sbm_pkg::BUSY_MODE_CODE));
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_busy_o <= 1'b0;
    end else if (busy_set) begin
      rx_busy_o <= 1'b1;
    end else if (core_i.busy_clear) begin
      rx_busy_o <= 1'b0;
    end
  end
  // Chained block read responses ignore busy mode
  assign ack_busy_o = rx_busy_o && !core_i.rx_chain_read_resp;

  // ==========================================================================
  // Live status word, no storage so reads cannot disturb it
  logic [15:0] status;
  logic [sbm_pkg::NUM_BANKS-1:0] used;
  logic live;
  always_comb begin
    used = bank_mask(mode.bank_div);
    live = released;
    status[15] = core_i.instruction_busy || !live;
    status[14] = live && !core_i.bus_reset && !core_i.forced_sleep;
    status[13] = core_i.xfer_active;
    status[12] = mode.status_select ? |(core_i.bank_has_data & used)
                                    : core_i.iso_cycle;
    status[11] = core_i.atx_empty;
    status[10] = core_i.arx_empty;
    status[9] = |(~core_i.bank_has_data & used);
    status[8] = !core_i.atx_full;
    status[7] = !core_i.arx_full;
    status[6] = |(~core_i.bank_full & used);
    status[5] = live;
    status[4] = core_i.forced_sleep;
    status[3] = !core_i.arx_empty;
    status[2] = rx_busy_o;
    status[1] = cycle_master_o;
    status[0] = core_i.int_pending;
  end

  // ==========================================================================
  // Read path: data refreshed every cycle of a selected read
  logic reading;
  assign reading = !cs_b_s && !rd_b_s;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dat_o <= 16'h0000;
      dat_oe_o <= 1'b0;
    end else begin
      dat_oe_o <= reading;
      if (reading) begin
        unique case (adr_s)
          sbm_pkg::MODE_IDX: dat_o <= mode;
          sbm_pkg::STATUS_IDX: dat_o <= status;
          default: dat_o <= sbm_pkg::UNMAPPED_READ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_mode_unused_zero: assert property ((mode & ~sbm_pkg::MODE_WMASK) == 16'h0000)
    else $error("unused mode bits set");
  a_bank_four_mask: assert property (mode.bank_div[1] |-> banks_used_o == 4'hf)
    else $error("four-bank decode wrong");
  a_bank_two_mask: assert property (mode.bank_div == 2'h1 |-> banks_used_o == 4'h3)
    else $error("two-bank decode wrong");
  a_chain_en_holds: assert property (mode.chain_en && !wr_commit |=> mode.chain_en)
    else $error("chain enable dropped without a write");
  a_pad_value: assert property (pad_fill_o == {8{mode.pad_ones}})
    else $error("pad fill wrong");
  a_sleep_valid: assert property (!mode.stay_awake && core_i.forced_sleep
    |-> !link_state_valid_o)
    else $error("link state valid during sleep");
  a_status_sel: assert property (mode.status_select && !(|core_i.bank_has_data)
    |-> !status[12])
    else $error("bank data flag wrong");
  a_cm_needs_root: assert property (core_i.bus_reset_done && !core_i.won_root
    |=> !cycle_master_o)
    else $error("cycle master without root");
  a_cm_enabled: assert property (core_i.bus_reset_done && core_i.won_root
    && mode.cycle_master_enable |=> cycle_master_o)
    else $error("cycle master not taken");
  a_selfid_keep: assert property (selfid_keep_o == mode.self_identification_store)
    else $error("self-ID store not followed");
  a_instr_busy_flag: assert property (core_i.instruction_busy |-> status[15])
    else $error("instruction busy not shown");
  a_ready_in_reset: assert property (core_i.bus_reset || core_i.forced_sleep
    |-> !status[14])
    else $error("transfer ready during reset or sleep");
  a_tran_busy: assert property (status[13] == core_i.xfer_active)
    else $error("transfer busy mismatch");
  a_rx_empty_req: assert property (status[10] != status[3])
    else $error("empty and data request agree");
  a_avail_flags: assert property (core_i.atx_full |-> !status[8])
    else $error("tx space shown when full");
  a_release_lock: assert property (!released |-> !layers_run_o && !status[5]
    && !status[14])
    else $error("layers run before lock");
  a_sleep_flag: assert property (status[4] == core_i.forced_sleep)
    else $error("sleep flag mismatch");
  a_busy_set_wins: assert property (busy_set |=> rx_busy_o)
    else $error("busy set lost");
  a_ack_busy: assert property (ack_busy_o |-> rx_busy_o && !core_i.rx_chain_read_resp)
    else $error("busy ack outside busy mode");
  a_int_flag: assert property (status[0] == core_i.int_pending)
    else $error("interrupt flag mismatch");
  a_read_no_change: assert property (reading && !wr_commit |=> $stable(mode))
    else $error("read altered mode");

  // Write, decode and handshake checks; a bus reset alone must drop mastership
  a_mode_write: assert property (wr_commit && adr_s == sbm_pkg::MODE_IDX
    |=> mode == ($past(dat_s) & sbm_pkg::MODE_WMASK))
    else $error("mode write not taken");
  a_status_write_ignored: assert property (wr_commit && adr_s != sbm_pkg::MODE_IDX
    |=> $stable(mode))
    else $error("write to other word changed mode");
  a_bank_one_mask: assert property (mode.bank_div == sbm_pkg::BANK_ONE
    |-> banks_used_o == sbm_pkg::BANKS_ONE_MASK)
    else $error("one-bank decode wrong");
  a_busy_clears: assert property (core_i.busy_clear && !busy_set
    |=> !rx_busy_o)
    else $error("busy mode not left");
  a_cm_bus_reset: assert property (core_i.bus_reset && !core_i.bus_reset_done
    |=> !cycle_master_o)
    else $error("cycle master kept through bus reset");
  a_ready_live: assert property (released && !core_i.bus_reset
    && !core_i.forced_sleep |-> status[14])
    else $error("transfer ready missing");
  a_oe_follows_read: assert property (reading |=> dat_oe_o)
    else $error("read not driven");
  a_oe_idle: assert property (!reading |=> !dat_oe_o)
    else $error("data bus driven while idle");

  c_mode_write: cover property (wr_commit && adr_s == sbm_pkg::MODE_IDX);
  c_status_read: cover property (reading && adr_s == sbm_pkg::STATUS_IDX);
  c_become_master: cover property (core_i.bus_reset_done ##1 cycle_master_o);
  c_busy_and_clear: cover property (busy_set && core_i.busy_clear);
  c_chain_exempt: cover property (rx_busy_o && core_i.rx_chain_read_resp);
endmodule // sbm_regs
`default_nettype wire

// ==== tb/sbm_host_model.sv ====
// Purpose: Host processor model driving the register bus pins of the bank
// Assumes: Strobes held well past the synchroniser delay of the bank
// Notes: Data pins show the inverse of the last word when not writing
`timescale 1ns/1ps
`default_nettype none
module sbm_host_model (
  input wire logic core_clk_i, // Core clock
  input wire logic [15:0] rdat_i, // Read data from the bank
  input wire logic rdat_oe_i, // Bank drives the data bus
  output logic cs_b_o, // Chip select, active low
  output logic rd_b_o, // Read strobe, active low
  output logic wr_b_o, // Write strobe, active low
  output logic [sbm_pkg::ADR_W-1:0] adr_o, // Word address
  output logic [15:0] wdat_o // Write data
);
  // ==========================================================================
  // Idle levels
  initial begin
    cs_b_o = 1'b1;
    rd_b_o = 1'b1;
    wr_b_o = 1'b1;
    adr_o = '0;
    wdat_o = 16'h0000;
  end

  // Whole 16-bit words only, no byte lanes
  task automatic write_word(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    cs_b_o <= 1'b0;
    adr_o <= a;
    wdat_o <= d;
    wr_b_o <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    wr_b_o <= 1'b1;
    // Address and data held past strobe release for the filter
    repeat (6) @(posedge core_clk_i);
    cs_b_o <= 1'b1;
    wdat_o <= ~d;
    repeat (4) @(posedge core_clk_i);
  endtask

  // Read samples at an edge once the bank drives; no side effect expected
  task automatic read_word(input logic [4:0] a, output logic [15:0] d,
                           output logic oe);
    @(posedge core_clk_i);
    cs_b_o <= 1'b0;
    rd_b_o <= 1'b0;
    adr_o <= a;
    repeat (8) @(posedge core_clk_i);
    d = rdat_i;
    oe = rdat_oe_i;
    rd_b_o <= 1'b1;
    cs_b_o <= 1'b1;
    repeat (6) @(posedge core_clk_i);
  endtask
endmodule // sbm_host_model
`default_nettype wire

// ==== tb/tb_serial_bus_mode_and_status_regs.sv ====
// Purpose: Self-checking bench for the mode and status register bank
// Assumes: Core state driven directly; pins driven by the host model
// Notes: Status expectations assume all four banks in use
`timescale 1ns/1ps
`default_nettype none
module tb_serial_bus_mode_and_status_regs;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic pll_locked_i = 1'b0;
  sbm_pkg::sbm_core_s core = '0;
  logic cs_b, rd_b, wr_b, dat_oe, ack_busy, cm_out, rx_busy, run, sleep_ok, link_ok, sid, bts;
  logic [4:0] adr;
  logic [15:0] wdat, rdat, d;
  logic [3:0] banks;
  logic [7:0] pad;
  sbm_pkg::sbm_mode_s mode;
  logic oe;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // ==========================================================================
  // Clock, timeout and instances
  always #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  sbm_host_model sbm_host_model_inst (.core_clk_i(core_clk_i), .rdat_i(rdat),
    .rdat_oe_i(dat_oe), .cs_b_o(cs_b), .rd_b_o(rd_b), .wr_b_o(wr_b), .adr_o(adr),
    .wdat_o(wdat));
  sbm_regs sbm_regs_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b),
    .rd_b_i(rd_b), .wr_b_i(wr_b), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
    .dat_oe_o(dat_oe), .pll_locked_i(pll_locked_i), .core_i(core), .mode_o(mode),
    .banks_used_o(banks), .pad_fill_o(pad), .block_to_shared_o(bts), .layers_run_o(run),
    .sleep_allowed_o(sleep_ok), .link_state_valid_o(link_ok), .cycle_master_o(cm_out),
    .selfid_keep_o(sid), .rx_busy_o(rx_busy), .ack_busy_o(ack_busy));

  // ==========================================================================
  // Shared helpers
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd(input logic [4:0] a);
    sbm_host_model_inst.read_word(a, d, oe);
    check("read enable", 16'h0001, {15'h0, oe});
  endtask

  // Pulse the core fields set in the mask for a single cycle through a set/clear mask
  task automatic pulse(input sbm_pkg::sbm_core_s m);
    @(posedge core_clk_i);
    core <= core | m;
    @(posedge core_clk_i);
    core <= core & ~m;
    repeat (2) @(posedge core_clk_i);
  endtask

  // Status word rebuilt from the live core state, bit 15 first
  // Busy mode and mastership are known idle while this is used
  function automatic logic [15:0] exp_status(sbm_pkg::sbm_core_s c, logic sel);
    exp_status = {c.instruction_busy, ~c.bus_reset & ~c.forced_sleep, c.xfer_active,
      sel ? |c.bank_has_data : c.iso_cycle, c.atx_empty, c.arx_empty, ~&c.bank_has_data,
      ~c.atx_full, ~c.arx_full, ~&c.bank_full, 1'b1, c.forced_sleep, ~c.arx_empty,
      2'h0, c.int_pending};
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_reset_release;
    rd(5'h00);
    check("mode reset", 16'h0002, d);
    rd(5'h01);
    check("release flag low", 16'h0000, d & 16'h0020);
    check("run before lock", 16'h0000, {15'h0, run});
    pll_locked_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    check("run after lock", 16'h0001, {15'h0, run});
  endtask

  task automatic t_mode_fields;
    sbm_host_model_inst.write_word(5'h00, 16'hffff);
    rd(5'h00);
    check("unused bits", 16'h6ecf, d);
    check("mode port", 16'h6ecf, mode);
    check("routing", 16'h0001, {15'h0, bts});
    check("awake", 16'h0001, {15'h0, link_ok & ~sleep_ok});
    check("selfid keep", 16'h0001, {15'h0, sid});
    for (int i = 0; i < 4; i++) begin
      sbm_host_model_inst.write_word(5'h00, {1'b0, i[1:0], 5'h0, i[0], 7'h0});
      check("banks", (i == 0) ? 16'h1 : (i == 1) ? 16'h3 : 16'hf, {12'h0, banks});
      check("pad", i[0] ? 16'h00ff : 16'h0000, {8'h0, pad});
    end
    core.forced_sleep <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    check("sleep link", 16'h0000, {15'h0, link_ok | ~sleep_ok | sid});
    core.forced_sleep <= 1'b0;
  endtask

  task automatic t_refused;
    sbm_host_model_inst.write_word(5'h01, 16'h1234);
    rd(5'h00);
    check("status write ignored", 16'h6080, d);
    rd(5'h03);
    check("unmapped read", 16'h0000, d);
  endtask

  task automatic t_status;
    sbm_pkg::sbm_core_s p [3];
    p[0] = '0;
    p[0].atx_empty = 1'b1;
    p[0].arx_empty = 1'b1;
    p[1] = '0;
    {p[1].instruction_busy, p[1].bus_reset, p[1].xfer_active, p[1].iso_cycle} = 4'hf;
    {p[1].atx_full, p[1].arx_full, p[1].int_pending} = 3'h7;
    p[1].bank_has_data = 4'h3;
    p[1].bank_full = 4'hf;
    p[2] = '0;
    p[2].forced_sleep = 1'b1;
    p[2].bank_has_data = 4'hf;
    for (int i = 0; i < 6; i++) begin
      sbm_host_model_inst.write_word(5'h00, i[0] ? 16'h6008 : 16'h6000);
      core <= p[i / 2];
      rd(5'h01);
      check("status", exp_status(p[i / 2], i[0]), d);
    end
    core <= '0;
  endtask

  task automatic t_busy_mode;
    sbm_pkg::sbm_core_s m;
    m = '0;
    m.rx_async_pkt = 1'b1;
    pulse(m);
    check("busy async", 16'h0001, {15'h0, rx_busy & ack_busy});
    core.rx_chain_read_resp <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    check("chain resp ack", 16'h0000, {15'h0, ack_busy});
    rd(5'h01);
    check("busy flag", 16'h0004, d & 16'h0004);
    m = '0;
    m.busy_clear = 1'b1;
    pulse(m);
    check("busy cleared", 16'h0000, {15'h0, rx_busy});
    rd(5'h01);
    check("instr ready", 16'h0000, d & 16'h8000);
    core.instr_code <= 8'h04;
    m = '0;
    m.instr_strobe = 1'b1;
    pulse(m);
    check("other code", 16'h0000, {15'h0, rx_busy});
    core.instr_code <= 8'h03;
    pulse(m);
    check("busy instr", 16'h0001, {15'h0, rx_busy});
    m = '0;
    m.busy_clear = 1'b1;
    pulse(m);
    m = '0;
    m.rx_selfid_pkt = 1'b1;
    pulse(m);
    check("busy selfid", 16'h0001, {15'h0, rx_busy});
    m.busy_clear = 1'b1;
    pulse(m);
    check("set beats clear", 16'h0001, {15'h0, rx_busy});
  endtask

  // Mid-run reset: flags and mode return to reset values, release follows lock
  task automatic t_reset_again;
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    check("reset mode", 16'h0002, mode);
    check("reset flags", 16'h0000, {13'h0, rx_busy, cm_out, run});
    rst_b_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    check("rerun after lock", 16'h0001, {15'h0, run});
  endtask

  task automatic t_cycle_master;
    sbm_pkg::sbm_core_s m;
    m = '0;
    m.bus_reset_done = 1'b1;
    sbm_host_model_inst.write_word(5'h00, 16'h0c04);
    core.won_root <= 1'b1;
    pulse(m);
    check("cm won", 16'h0001, {15'h0, cm_out});
    rd(5'h01);
    check("cm flag", 16'h0002, d & 16'h0002);
    core.won_root <= 1'b0;
    pulse(m);
    check("cm lost root", 16'h0000, {15'h0, cm_out});
    rd(5'h00);
    check("chain kept", 16'h0c04, d);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_reset_release();
    t_mode_fields();
    t_refused();
    t_status();
    t_busy_mode();
    t_cycle_master();
    t_reset_again();
    report_and_stop();
  end
endmodule // tb_serial_bus_mode_and_status_regs
`default_nettype wire
